// ### core/bit_counter.sv
// Purpose: set-bit count and leading-zero count over a 64-bit word
// Assumes: narrow operands arrive in the low bits
// Notes: purely combinational; the caller registers the result
module bit_counter #(
	parameter int WIDTH = 64
) (
	input wire logic [WIDTH-1:0] operand,
	input wire logic wide_mode,
	output logic [$clog2(WIDTH):0] ones,
	output logic [$clog2(WIDTH):0] lead_zeros,
	output logic [$clog2(WIDTH)-1:0] msb_index
);
	localparam int CW = $clog2(WIDTH) + 1;
	// ==========================================
	// counting
	// upper half is masked in narrow mode so stray high bits never count
	always_comb begin
		logic [WIDTH-1:0] word;
		logic found;
		word = wide_mode ? operand : {{(WIDTH/2){1'b0}}, operand[WIDTH/2-1:0]};
		ones = '0;
		found = 1'b0;
		lead_zeros = wide_mode ? CW'(WIDTH) : CW'(WIDTH/2);
		msb_index = '0;
		for (int i = 0; i < WIDTH; i++) begin
			ones = ones + CW'(word[i]); // RQ5
		end
		// scan down from the top; first one seen stops the count
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (!found && word[i]) begin
				found = 1'b1;
				msb_index = ($clog2(WIDTH))'(i);
				lead_zeros = (wide_mode ? CW'(WIDTH - 1) : CW'(WIDTH/2 - 1)) - CW'(i); // RQ6 RQ7
			end
		end
	end
endmodule

// ### core/int_divide_bitcount_unit.sv
// Purpose: integer divide with data-dependent latency plus bit counting
// Assumes: issue pipeline holds request until accepted (req_ready)
// Notes: one operation in flight; divide restores bit-serially then waits out latency
// Behaviour
// [RQ1] divide latency follows 16/32/64 operand width
// [RQ2] unsigned msb at bits 0-2: twenty cycles
// [RQ3] unsigned msb 3 or above: sixteen plus index
// [RQ4] signed: twenty-four plus msb index of magnitude
// [RQ5] set bit count returns number of ones
// [RQ6] leading zeros counted from msb downward
// [RQ7] counts use 32 or 64 bits by mode
// [RQ8] zero, oversize, 8-bit divides take fixed twenty
module int_divide_bitcount_unit #(
	parameter int WIDTH = 64
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [1:0] req_width,
	input wire logic wide_mode,
	input wire logic [WIDTH-1:0] dividend,
	input wire logic [WIDTH-1:0] divisor,
	output logic res_valid,
	output logic [WIDTH-1:0] quotient,
	output logic [WIDTH-1:0] remainder,
	output logic [WIDTH-1:0] count_result,
	output logic div_by_zero
);
	localparam int LW = 8; // latency counter width
	localparam int IW = $clog2(WIDTH);
	// sequencer: IDLE takes requests, DIVIDE shifts, WAIT pads latency, DONE answers
	typedef enum logic [1:0] {IDLE, DIVIDE, WAIT, DONE} state_t;
	state_t state;
	// ==========================================
	// width codes
	// local copies keep the case labels short; the package stays the only source
	localparam logic [1:0] WIDTH_SEL_16 = int_unit_pkg::WIDTH_16;
	localparam logic [1:0] WIDTH_SEL_32 = int_unit_pkg::WIDTH_32;
	localparam logic [1:0] WIDTH_SEL_64 = int_unit_pkg::WIDTH_64;
	// ==========================================
	// operand conditioning
	logic [WIDTH-1:0] width_mask; // live bits of this divide width
	logic [WIDTH-1:0] sign_bits; // one-hot sign position
	logic signed_op;
	logic dvd_neg, dsr_neg;
	logic [WIDTH-1:0] dvd_mag, dsr_mag;
	logic [IW:0] ones_unused, lz_unused;
	logic [IW-1:0] msb_idx;
	logic [IW:0] cnt_ones, cnt_lz;
	logic [IW-1:0] cnt_msb_unused;
	logic [LW-1:0] next_latency; // cycles the request must take
	// mask and sign position by width
	always_comb begin
		unique case (req_width)
			WIDTH_SEL_16: begin
				width_mask = WIDTH'(16'hFFFF);
				sign_bits = WIDTH'(16'h8000);
			end
			WIDTH_SEL_32: begin
				width_mask = WIDTH'(32'hFFFF_FFFF);
				sign_bits = WIDTH'(32'h8000_0000);
			end
			WIDTH_SEL_64: begin
				width_mask = '1;
				sign_bits = {1'b1, {(WIDTH-1){1'b0}}};
			end
			default: begin
				width_mask = WIDTH'(8'hFF);
				sign_bits = WIDTH'(8'h80);
			end
		endcase
	end
	// signed handling only for the signed_divide code; unsigned keeps raw bits
	assign signed_op = (req_op == int_unit_pkg::OP_SIGNED_DIVIDE);
	assign dvd_neg = signed_op && |(dividend & sign_bits);
	assign dsr_neg = signed_op && |(divisor & sign_bits);
	// magnitudes within the chosen width; upper bits cleared
	assign dvd_mag = (dvd_neg ? (~dividend + WIDTH'(1)) : dividend) & width_mask;
	assign dsr_mag = (dsr_neg ? (~divisor + WIDTH'(1)) : divisor) & width_mask;
	// msb of dividend magnitude found by the shared counter
	bit_counter #(.WIDTH(WIDTH)) u_msb (
		.operand(dvd_mag),
		.wide_mode(1'b1),
		.ones(ones_unused),
		.lead_zeros(lz_unused),
		.msb_index(msb_idx)
	);
	// counts of the bit-count operand itself
	// the counter sees the raw operand; narrow mode masking happens inside it
	bit_counter #(.WIDTH(WIDTH)) u_count (
		.operand(dividend),
		.wide_mode(wide_mode), // RQ7
		.ones(cnt_ones),
		.lead_zeros(cnt_lz),
		.msb_index(cnt_msb_unused)
	);
	// ==========================================
	// latency selection
	// a magnitude at or above 2^width cannot arise after masking, not even for the
	// signed minimum, whose magnitude lands on the sign bit and still follows the sum
	// the fallback branch wins first, so 8-bit and zero never reach the sums
	// the counter is 8 bits: 24 plus 63 is the largest figure, well inside
	always_comb begin
		if (req_width == int_unit_pkg::WIDTH_8 || dvd_mag == '0) begin
			next_latency = LW'(int_unit_pkg::DIV_FALLBACK_LATENCY); // RQ8
		end else if (signed_op) begin
			next_latency = LW'(int_unit_pkg::SDIV_BASE_LATENCY) + LW'(msb_idx); // RQ4
		end else if (32'(msb_idx) < int_unit_pkg::DIV_SMALL_MSB_LIMIT) begin
			next_latency = LW'(int_unit_pkg::DIV_SMALL_LATENCY); // RQ2
		end else begin
			next_latency = LW'(int_unit_pkg::DIV_BASE_LATENCY) + LW'(msb_idx); // RQ3 RQ1
		end
	end
	// ==========================================
	// divide state
	// remaining is loaded one short because the accepting edge counts as the first
	// step never outlasts remaining: latency exceeds the bit count by twelve or more, twelve being an 8-bit divide with msb 7
	logic [LW-1:0] remaining; // cycles left until result
	logic [IW:0] step; // bits left to shift through
	logic [WIDTH-1:0] acc_q, acc_r, dsr_hold;
	logic neg_q, neg_r, zero_div;
	logic [WIDTH:0] trial;
	logic accept;
	assign req_ready = (state == IDLE);
	assign accept = req_valid && req_ready;
	assign trial = {acc_r, acc_q[WIDTH-1]} - {1'b0, dsr_hold};
	// sequencer: one bit per cycle from the top, then idle until latency expires;
	// 64 restoring steps may exceed the documented latency, so the count, not
	// the arithmetic, sets when the result appears (arithmetic finishes first
	// only because the quotient is pre-shifted past leading zeros)
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= IDLE;
			remaining <= '0;
			step <= '0;
		end else begin
			unique case (state)
				IDLE: begin
					// bit counts skip the divide path entirely
					if (accept && req_op[1]) begin
						state <= DONE; // bit counts finish next cycle
					end else if (accept) begin
						state <= DIVIDE;
						remaining <= next_latency - LW'(1);
						step <= (IW+1)'(msb_idx) + (IW+1)'(1);
					end
				end
				DIVIDE: begin
					remaining <= remaining - LW'(1);
					step <= step - (IW+1)'(1);
					if (step == (IW+1)'(1)) begin
						state <= (remaining == LW'(1)) ? DONE : WAIT;
					end
				end
				WAIT: begin
					remaining <= remaining - LW'(1);
					if (remaining == LW'(1)) begin
						state <= DONE;
					end
				end
				DONE: begin
					// one cycle only: the pulse and the return to IDLE share it
					state <= IDLE;
				end
			endcase
		end
	end
	// datapath: quotient pre-aligned so its msb enters the remainder first
	// signs are applied only at the end, so the loop works on magnitudes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_q <= '0;
			acc_r <= '0;
			dsr_hold <= '0;
			neg_q <= 1'b0;
			neg_r <= 1'b0;
			zero_div <= 1'b0;
		end else if (accept && !req_op[1]) begin
			acc_q <= dvd_mag << (WIDTH - 1 - int'(msb_idx));
			acc_r <= '0;
			dsr_hold <= dsr_mag;
			neg_q <= dvd_neg ^ dsr_neg;
			neg_r <= dvd_neg;
			zero_div <= (dsr_mag == '0);
		end else if (state == DIVIDE) begin
			if (!trial[WIDTH]) begin
				acc_r <= trial[WIDTH-1:0];
				acc_q <= {acc_q[WIDTH-2:0], 1'b1};
			end else begin
				acc_r <= {acc_r[WIDTH-2:0], acc_q[WIDTH-1]};
				acc_q <= {acc_q[WIDTH-2:0], 1'b0};
			end
		end
	end
	// ==========================================
	// result registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			res_valid <= 1'b0;
			quotient <= '0;
			remainder <= '0;
			count_result <= '0;
			div_by_zero <= 1'b0;
		end else begin
			res_valid <= 1'b0;
			// count results are taken at the accepting edge from the combinational counter
			if (accept && req_op == int_unit_pkg::OP_SET_BIT_COUNT) begin
				count_result <= WIDTH'(cnt_ones); // RQ5
			end else if (accept && req_op == int_unit_pkg::OP_LEADING_ZERO_COUNT) begin
				count_result <= WIDTH'(cnt_lz); // RQ6
			end
			if (state == DONE) begin
				res_valid <= 1'b1;
			end
			// a zero divisor gives all ones and a zero remainder instead of a trap
			// divide answers one cycle before DONE leaves, so res_valid and data align
			if ((state == DIVIDE || state == WAIT) && remaining == LW'(1)) begin
				quotient <= zero_div ? '1 : (neg_q ? (~acc_q + WIDTH'(1)) : acc_q);
				remainder <= zero_div ? '0 : (neg_r ? (~acc_r + WIDTH'(1)) : acc_r);
				div_by_zero <= zero_div;
			end
		end
	end
endmodule

// ### core/int_unit_pkg.sv
// Purpose: shared constants for the integer divide and bit-count unit
// Assumes: single core clock, no software-visible registers
// Notes: latencies are in core clock cycles, counted from request to result
package int_unit_pkg;
	// ==========================================
	// operation and width codes
	localparam logic [1:0] OP_DIVIDE = 2'h0; // unsigned divide
	localparam logic [1:0] OP_SIGNED_DIVIDE = 2'h1; // signed_divide
	localparam logic [1:0] OP_SET_BIT_COUNT = 2'h2; // set_bit_count
	localparam logic [1:0] OP_LEADING_ZERO_COUNT = 2'h3; // leading_zero_count
	localparam logic [1:0] WIDTH_8 = 2'h0; // 8-bit divide, not characterised
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;
	localparam logic [1:0] WIDTH_64 = 2'h3;
	// ==========================================
	// latency figures
	localparam int unsigned DIV_SMALL_LATENCY = 20; // msb at bit 0..2
	localparam int unsigned DIV_SMALL_MSB_LIMIT = 3; // first msb position using the sum
	localparam int unsigned DIV_BASE_LATENCY = 16; // unsigned base plus msb index
	localparam int unsigned SDIV_BASE_LATENCY = 24; // signed base plus msb index
	localparam int unsigned DIV_FALLBACK_LATENCY = 20; // zero/oversize/8-bit dividend
	localparam int unsigned COUNT_LATENCY = 1; // bit counts answer next cycle
endpackage

// ### verif/int_unit_checker.sv
// Purpose: port checks for the divide and bit-count unit
// Assumes: bound to the unit's top module
// Notes: delays count edges from the accepting edge
module int_unit_checker #(
	parameter int WIDTH = 64
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic wide_mode,
	input wire logic res_valid,
	input wire logic [1:0] req_op,
	input wire logic [1:0] req_width,
	input wire logic [WIDTH-1:0] dividend,
	input wire logic [WIDTH-1:0] count_result
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// request decode
	logic is_div, is_cnt, is_pop, is_lz; // strobes of accepted requests by kind
	assign is_div = req_valid && req_ready && !req_op[1];
	assign is_cnt = req_valid && req_ready && req_op[1];
	assign is_pop = is_cnt && !req_op[0];
	assign is_lz = is_cnt && req_op[0];
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// counts stay quiet one edge, then answer
	sequence count_answer;
		##1 !res_valid ##1 res_valid;
	endsequence
	// ==========
	// properties
	cnt_lat_a: assert property (is_cnt |-> count_answer) else $error("count latency");
	div_min_a: assert property (is_div |=> (!res_valid)[*8]) else $error("early divide");
	small_lat_a: assert property (is_div && !req_op[0] && req_width == int_unit_pkg::WIDTH_16
		&& dividend[15:3] == 13'h0 && dividend[2:0] != 3'h0 |-> ##21 res_valid) else $error("small divide");
	zero_lat_a: assert property (is_div && dividend == '0 |-> ##21 res_valid) else $error("zero divide");
	sdiv_lat_a: assert property (is_div && req_op[0] && req_width == int_unit_pkg::WIDTH_16
		&& dividend[15:0] == 16'h1 |-> ##25 res_valid) else $error("signed divide");
	pop_val_a: assert property (is_pop |-> ##2 count_result ==
		$countones($past(wide_mode, 2) ? $past(dividend, 2) : $past(dividend[31:0], 2))) else $error("bit count");
	lz_zero_a: assert property (is_lz && !wide_mode && dividend[31:0] == 32'h0 |-> ##2 count_result == 64'h20)
		else $error("zero lead count");
	lz_top_a: assert property (is_lz && wide_mode && dividend[WIDTH-1] |-> ##2 count_result == 64'h0)
		else $error("top lead count");
	ready_busy_a: assert property (is_div |=> !req_ready) else $error("busy divide took request");
endmodule
bind int_divide_bitcount_unit int_unit_checker #(.WIDTH(WIDTH)) chk_u (.ref_clk(ref_clk), .rst(rst),
	.req_valid(req_valid), .req_ready(req_ready), .wide_mode(wide_mode), .res_valid(res_valid),
	.req_op(req_op), .req_width(req_width), .dividend(dividend), .count_result(count_result));

// ### verif/issue_model.sv
// Purpose: issue pipeline model that feeds the unit
// Assumes: the bench raises go for one edge per request
// Notes: the operand is inverted once taken, so no stale value looks held
module issue_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic mode,
	input wire logic req_ready,
	input wire logic [1:0] op,
	input wire logic [1:0] w,
	input wire logic [63:0] a,
	output logic req_valid,
	output logic wide_mode,
	output logic [1:0] req_op,
	output logic [1:0] req_width,
	output logic [63:0] dividend
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// request holding
	// the request stands unchanged until req_ready is sampled high
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{req_valid, req_op, req_width, wide_mode, dividend} <= '0;
		end else if (go && !req_valid) begin
			{req_valid, req_op, req_width, wide_mode, dividend} <= {1'b1, op, w, mode, a};
		end else if (req_valid && req_ready) begin
			{req_valid, dividend} <= {1'b0, ~dividend};
		end
	end
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench for the divide and bit-count unit
// Assumes: divisor set per divide case; results are judged on timing, counts and quotients
// Notes: latency is counted in edges after the accepting edge
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// signals
	logic ref_clk, rst, go, mode, req_valid, req_ready, wide_mode, res_valid, div_by_zero;
	logic [1:0] op, w, req_op, req_width;
	logic [63:0] a, dividend, count_result, quotient, remainder;
	logic [63:0] dsr; // divisor, changed only between divides
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int lat; // edges from accept to answer
	issue_model pm_u (.ref_clk(ref_clk), .rst(rst), .go(go), .mode(mode), .req_ready(req_ready), .op(op),
		.w(w), .a(a), .req_valid(req_valid), .wide_mode(wide_mode), .req_op(req_op), .req_width(req_width),
		.dividend(dividend));
	int_divide_bitcount_unit dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_width(req_width), .wide_mode(wide_mode), .dividend(dividend), .divisor(dsr),
		.res_valid(res_valid), .quotient(quotient), .remainder(remainder), .count_result(count_result),
		.div_by_zero(div_by_zero));
	// ==========
	// shared tasks
	task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic test_done();
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// issue one request, wait for its acceptance, then count edges to the answer
	task automatic run(input logic [1:0] o, input logic [1:0] ww, input logic m, input logic [63:0] v);
		int i;
		@(posedge ref_clk);
		{go, op, w, mode, a} <= {1'b1, o, ww, m, v};
		@(posedge ref_clk);
		go <= 1'b0;
		for (i = 0; i < 9 && (req_valid & req_ready) !== 1'b1; i++) @(negedge ref_clk);
		for (lat = 0; lat < 200 && res_valid !== 1'b1; lat++) @(negedge ref_clk);
	endtask
	// l is the documented latency; the pulse lands one edge later
	// q and r are the expected results within the divide width
	task automatic dcase(input logic sg, input int bits, input logic [63:0] v, input logic [63:0] d, input int l,
		input logic [63:0] q, input logic [63:0] r);
		logic [63:0] m;
		m = {64{1'b1}} >> (64 - bits);
		@(posedge ref_clk);
		dsr <= d;
		run({1'b0, sg}, 2'($clog2(bits) - 3), 1'b1, v);
		check("latency", 64'(lat), 64'(l + 1));
		check("quotient", quotient & m, q);
		check("remainder", remainder & m, r);
		check("div_by_zero", 64'(div_by_zero), 64'(d == 64'h0));
	endtask
	task automatic ccase(input logic lz, input logic m, input logic [63:0] v, input logic [63:0] c);
		run({1'b1, lz}, int_unit_pkg::WIDTH_64, m, v);
		check("latency", 64'(lat), 64'h2);
		check("count", count_result, c);
	endtask
	// ==========
	// scenarios
	task automatic t_udiv();
		dcase(1'b0, 16, 64'h7, 64'h3, 20, 64'h2, 64'h1);
		dcase(1'b0, 16, 64'h8, 64'h3, 19, 64'h2, 64'h2);
		dcase(1'b0, 16, 64'h1_0008, 64'h3, 19, 64'h2, 64'h2);
		dcase(1'b0, 64, 64'h8000_0000_0000_0000, 64'h3, 79, 64'h2AAA_AAAA_AAAA_AAAA, 64'h2);
		dcase(1'b0, 8, 64'h5, 64'h3, 20, 64'h1, 64'h2);
		dcase(1'b0, 16, 64'h0, 64'h3, 20, 64'h0, 64'h0);
		dcase(1'b0, 16, 64'h9, 64'h0, 19, 64'hFFFF, 64'h0);
	endtask
	task automatic t_sdiv();
		dcase(1'b1, 16, 64'h1, 64'h3, 24, 64'h0, 64'h1);
		dcase(1'b1, 32, 64'hFFFF_FFF8, 64'h3, 27, 64'hFFFF_FFFE, 64'hFFFF_FFFE);
	endtask
	task automatic t_count();
		ccase(1'b0, 1'b1, 64'hFFFF_0000_0000_0001, 64'h11);
		ccase(1'b0, 1'b0, 64'hFFFF_0000_0000_0001, 64'h1);
		ccase(1'b1, 1'b1, 64'h1, 64'h3F);
		ccase(1'b1, 1'b0, 64'hFFFF_0000_0000_0000, 64'h20);
		ccase(1'b1, 1'b1, 64'h8000_0000_0000_0000, 64'h0);
	endtask
	// ==========
	// clock, reset, main sequence, hang guard
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		{rst, go, op, w, mode, a} = {1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 64'h0};
		dsr = 64'h3;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_udiv();
		t_sdiv();
		t_count();
		test_done();
	end
	// the whole run needs under two thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end
endmodule
